/* File: src/fbod_host.sv */
// Host controller driving a parallel NOR flash through its bus pins.
// Assumes flash pins are synchronous to CLK and data bus is resolved outside.
// Operation
// RL1 - Read: chip select and output gate low, write strobe high.
// RL2 - Write: write strobe and chip select low, output gate high.
// RL3 - Device keeps command latches unaddressed; host only sends cycles.
// RL4 - Width select high gives sixteen active data lines.
// RL5 - Width select low: low byte only, top data line carries byte address.
// RL6 - Word mode decodes address 20..0, byte mode adds byte address bit.
// RL7 - After reset the device reads array without any command.
// RL8 - Device stays in read array until a command write.
// RL9 - Program data goes as byte or word by width select.
// RL10 - In fast mode program takes two write cycles instead of four.
// RL11 - Device erases sector, several sectors or whole array.
// RL12 - After id sequence reads return id codes on low byte.
// RL13 - During program or erase reads return status on low byte.
// RL14 - Boost level enters fast mode and unprotects all sectors.
// RL15 - Protect pin low keeps two boot sectors protected.
// RL16 - Host never floats protect pin, boosts only for programming; code boosts whenever BOOST_EN is high, reads included.
// RL17 - Output gate high floats all device data outputs.
// RL18 - Reset low aborts, floats outputs, returns to read array.
// RL19 - Boost level is a separate digital qualifier signal.
`timescale 1ns/1ps
module fbod_host
  import fbod_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    SRST,
  // Request side
  input  wire fbod_pkg::fbod_req_t     REQ,
  input  wire logic                    REQ_VALID,
  output logic                         REQ_READY,
  input  wire logic                    BYTE_MODE,
  input  wire logic                    FAST_MODE,
  input  wire logic                    PROTECT_EN,
  input  wire logic                    BOOST_EN,
  output logic [fbod_pkg::DATA_W-1:0]  RD_DATA,
  output logic                         RD_VALID,
  // Flash pins
  output fbod_pkg::fbod_pins_t         PINS,
  output logic [fbod_pkg::DATA_W-1:0]  DQ_O,
  output logic [fbod_pkg::DATA_W-1:0]  DQ_OE_N,
  input  wire logic [fbod_pkg::DATA_W-1:0] DQ_I,
  output logic                         PROTECT_OR_BOOST_PIN,
  output logic                         BOOST_VOLTAGE_LEVEL
);
  import fbod_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h3,
    ST_GAP   = 3'h4,
    ST_RST   = 3'h5
  } fbod_state_t;

  fbod_state_t          state_q, state_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [1:0]           step_q, step_d;
  logic [1:0]           last_q, last_d;
  fbod_req_t            req_q, req_d;
  fbod_pins_t           pins_q, pins_d;
  logic [DATA_W-1:0]    dqo_q, dqo_d;
  logic                 dqoe_q, dqoe_d;
  logic [DATA_W-1:0]    rd_q, rd_d;
  logic                 rdv_q, rdv_d;

  // Address and data of one program cycle by step
  function automatic logic [ADDR_W+DATA_W-1:0] prog_cycle(input logic [1:0] s,
                                                           input logic [1:0] last,
                                                           input fbod_req_t r);
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    a = r.addr;
    d = r.data;
    if (s == last) begin
      a = r.addr;
      d = r.data;
    end else if (s == last - 2'h1) begin
      a = UNLOCK_A1;
      d = {8'h00, CMD_PROG};
    end else if (s == 2'h0) begin
      a = UNLOCK_A1;
      d = {8'h00, UNLOCK_D1};
    end else begin
      a = UNLOCK_A2;
      d = {8'h00, UNLOCK_D2};
    end
    return {a, d};
  endfunction

  // Next state of the bus sequencer
  always_comb begin
    logic [ADDR_W+DATA_W-1:0] pc;
    pc      = '0;
    state_d = state_q;
    cnt_d   = cnt_q;
    step_d  = step_q;
    last_d  = last_q;
    req_d   = req_q;
    pins_d  = pins_q;
    dqo_d   = dqo_q;
    dqoe_d  = dqoe_q;
    rd_d    = rd_q;
    rdv_d   = 1'b0;
    pins_d.width_select_n = ~BYTE_MODE;                      // [RL4] [RL5] [RL9]
    case (state_q)
      ST_IDLE: begin
        pins_d.chip_select_n  = 1'b1;
        pins_d.output_gate_n  = 1'b1;
        pins_d.write_strobe_n = 1'b1;
        pins_d.hw_reset_n     = 1'b1;
        dqoe_d                = 1'b1;
        if (REQ_VALID) begin
          req_d  = REQ;
          step_d = 2'h0;
          cnt_d  = '0;
          // Fast mode skips the two unlock cycles
          last_d = (FAST_MODE || BOOST_EN) ? 2'h1 : 2'h3;    // [RL10] [RL14]
          state_d = (REQ.op == OP_RESET) ? ST_RST : ST_SETUP;
          if (REQ.op == OP_PROG && (FAST_MODE || BOOST_EN)) begin
            step_d = 2'h2;
            last_d = 2'h3;
          end
        end
      end
      ST_SETUP: begin
        pins_d.addr = req_q.addr;                            // [RL6]
        if (req_q.op == OP_PROG) begin
          pc          = prog_cycle(step_q, last_q, req_q);
          pins_d.addr = pc[ADDR_W+DATA_W-1:DATA_W];
          dqo_d       = pc[DATA_W-1:0];
        end else begin
          dqo_d = req_q.data;                                // Erase, id cycles [RL11] [RL12]
        end
        // Byte mode puts the byte address on the top data line
        if (BYTE_MODE) begin
          dqo_d[DATA_W-1] = req_q.byte_lsb;                 // [RL5] [RL6]
        end
        pins_d.chip_select_n = 1'b0;
        cnt_d = '0;
        if (req_q.op == OP_READ) begin
          pins_d.output_gate_n  = 1'b0;                      // [RL1]
          pins_d.write_strobe_n = 1'b1;                      // No latch change [RL8]
          dqoe_d  = 1'b1;                                    // Flash owns the bus [RL17]
          state_d = ST_READ;
        end else begin
          pins_d.output_gate_n  = 1'b1;                      // [RL2] [RL17]
          pins_d.write_strobe_n = 1'b0;
          dqoe_d  = 1'b0;
          state_d = ST_WRITE;
        end
      end
      ST_READ: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(STROBE_CYC - 1)) begin
          // Array, id or status data sampled at end of strobe
          rd_d  = BYTE_MODE ? {8'h00, DQ_I[7:0]} : DQ_I;     // [RL12] [RL13]
          rdv_d = 1'b1;
          pins_d.output_gate_n = 1'b1;
          pins_d.chip_select_n = 1'b1;
          dqoe_d  = 1'b1;
          state_d = ST_GAP;
        end
      end
      ST_WRITE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(STROBE_CYC - 1)) begin
          pins_d.write_strobe_n = 1'b1;                      // Latch on rising edge [RL3]
          pins_d.chip_select_n  = 1'b1;
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        // Hold data one cycle past the strobe for hold time
        dqoe_d = 1'b1;
        if (req_q.op == OP_PROG && step_q != last_q) begin
          step_d  = step_q + 2'h1;
          state_d = ST_SETUP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_RST: begin
        pins_d.hw_reset_n    = 1'b0;                         // [RL18] [RL7]
        pins_d.chip_select_n = 1'b1;
        dqoe_d = 1'b1;
        cnt_d  = cnt_q + 1'b1;
        if (cnt_q == CNT_W'(RESET_CYC - 1)) begin
          pins_d.hw_reset_n = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      step_q  <= 2'h0;
      last_q  <= 2'h3;
      req_q   <= '0;
      pins_q  <= '{chip_select_n: 1'b1, output_gate_n: 1'b1, write_strobe_n: 1'b1,
                   hw_reset_n: 1'b0, width_select_n: 1'b1, addr: '0};
      dqo_q   <= '0;
      dqoe_q  <= 1'b1;
      rd_q    <= '0;
      rdv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      step_q  <= step_d;
      last_q  <= last_d;
      req_q   <= req_d;
      pins_q  <= pins_d;
      dqo_q   <= dqo_d;
      dqoe_q  <= dqoe_d;
      rd_q    <= rd_d;
      rdv_q   <= rdv_d;
    end
  end

  // Outputs; the protect pin is always driven, never floats
  assign REQ_READY            = (state_q == ST_IDLE);
  assign PINS                 = pins_q;
  assign DQ_O                 = dqo_q;
  // Top line still driven in byte mode as the byte address bit
  assign DQ_OE_N              = {pins_q.width_select_n ? dqoe_q : 1'b0,
                                 {(DATA_W-1){dqoe_q}}};
  assign PROTECT_OR_BOOST_PIN = ~PROTECT_EN | BOOST_EN;      // [RL15] [RL16]
  assign BOOST_VOLTAGE_LEVEL  = BOOST_EN;                    // [RL19] [RL14]
  assign RD_DATA              = rd_q;
  assign RD_VALID             = rdv_q;

  // Read strobe never overlaps write strobe
  property p_no_overlap;
    @(posedge CLK) disable iff (SRST)
      !(PINS.output_gate_n == 1'b0 && PINS.write_strobe_n == 1'b0);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("strobes overlap"); // [RL1]

  property p_write_drive;
    @(posedge CLK) disable iff (SRST)
      (PINS.write_strobe_n == 1'b0) |-> (PINS.chip_select_n == 1'b0 && DQ_OE_N[0] == 1'b0);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write without drive"); // [RL2]

  property p_read_float;
    @(posedge CLK) disable iff (SRST)
      (PINS.output_gate_n == 1'b0) |-> (DQ_OE_N[0] == 1'b1);
  endproperty
  a_read_float: assert property (p_read_float) else $error("bus driven during read"); // [RL17]

  property p_width;
    @(posedge CLK) disable iff (SRST)
      ##1 (PINS.width_select_n == ~$past(BYTE_MODE));
  endproperty
  a_width: assert property (p_width) else $error("width select wrong"); // [RL4]

  property p_boost;
    @(posedge CLK) disable iff (SRST)
      BOOST_EN |-> PROTECT_OR_BOOST_PIN;
  endproperty
  a_boost: assert property (p_boost) else $error("boost without pin high"); // [RL14]

  property p_protect;
    @(posedge CLK) disable iff (SRST)
      (PROTECT_EN && !BOOST_EN) |-> !PROTECT_OR_BOOST_PIN;
  endproperty
  a_protect: assert property (p_protect) else $error("protect pin not low"); // [RL15]

  property p_reset_float;
    @(posedge CLK) disable iff (SRST)
      (PINS.hw_reset_n == 1'b0) |-> (DQ_OE_N == {DATA_W{1'b1}} || !PINS.width_select_n);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("bus driven in reset"); // [RL18]

  sequence s_rd_start;
    $fell(PINS.output_gate_n);
  endsequence
  property p_rd_done;
    @(posedge CLK) disable iff (SRST)
      s_rd_start |-> ##[1:300] RD_VALID;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read never completes"); // [RL1]

endmodule // fbod_host

/* File: pkg/fbod_pkg.sv */
// Package for the host-side parallel flash bus controller.
// Holds pin bundle types, command codes, operation codes and timing counts.
package fbod_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CYCLE_TIME_NS = 100;   // Bus strobe width, plain default
  localparam int unsigned STROBE_CYC    = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_TIME_NS = 500;   // Reset pulse width, plain default
  localparam int unsigned RESET_CYC     = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 8;

  // Widths
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 16;

  // Unlock sequence addresses and data (word addressing)
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
  localparam logic [7:0]        UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]        UNLOCK_D2 = 8'h55;
  localparam logic [7:0]        CMD_PROG  = 8'hA0;
  localparam logic [7:0]        CMD_RESET = 8'hF0;

  // Host request opcodes
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,  // Array, id or status read
    OP_WRITE = 3'h1,  // Single raw command cycle
    OP_PROG  = 3'h2,  // Program, four cycles or two in fast mode
    OP_RESET = 3'h3   // Hardware reset pulse
  } fbod_op_t;

  typedef struct packed {
    fbod_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                byte_lsb;
  } fbod_req_t;

  // Pins driven toward the flash
  typedef struct packed {
    logic                chip_select_n;
    logic                output_gate_n;
    logic                write_strobe_n;
    logic                hw_reset_n;
    logic                width_select_n;
    logic [ADDR_W-1:0]   addr;
  } fbod_pins_t;

endpackage

/* File: tb/fbod_flash_model.sv */
// Behavioural model of the flash device seen by the host controller.
// Assumes pins change on the host clock and the bench resolves the data bus.
`timescale 1ns/1ps
module fbod_flash_model
  import fbod_pkg::*;
#(
  parameter int         BUSY_CYC   = 40,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value, not a real maker
  parameter logic [7:0] ERASE_CODE = 8'h80, // Erase setup, plain default
  parameter logic [7:0] SECT_CODE  = 8'h30  // Sector erase confirm, plain default
)(
  // Host side
  input  wire logic       clk,
  input  wire fbod_pins_t pins,
  input  wire logic [15:0] dq,
  input  wire logic       protect_pin,
  input  wire logic       boost_level,
  // Data drive, low enable drives a lane
  output logic [15:0]     dq_out,
  output logic [15:0]     dq_oe_n
);
  logic [15:0] mem [int];  // Sparse: unwritten words read a fixed pattern
  fbod_pins_t  p_q;
  logic [15:0] dq_q, last_d, word, lanes;
  logic        id_q = 1'b0;
  int          step = 0;
  int          busy = 0;
  logic [31:0] wiped = '0;  // Sectors erased since start read blank
  int          ks[$];

  function automatic logic [15:0] peek(logic [20:0] a);
    if (mem.exists(int'(a))) return mem[int'(a)];
    return wiped[a[20:16]] ? 16'hFFFF : a[15:0] ^ 16'h5A5A;
  endfunction

  // Outer boot sectors refuse programming unless released or boosted
  function automatic logic locked(logic [20:0] a);
    return !boost_level && !protect_pin && (a[20:16] == 5'h00 || a[20:16] == 5'h1F);
  endfunction

  // Command latches, taken when the write strobe rises; nothing addressable
  always @(posedge clk) begin
    if (busy > 0) busy = busy - 1;
    if (!pins.hw_reset_n) begin
      step = 0;
      id_q = 1'b0;
      busy = 0;
    end else if (!p_q.write_strobe_n && !p_q.chip_select_n && pins.write_strobe_n) begin
      if (step == 3) begin
        if (!locked(p_q.addr)) begin
          mem[int'(p_q.addr)] = dq_q;
          last_d = dq_q;
          busy = BUSY_CYC;
        end
        step = 0;
      end else if (dq_q[7:0] == CMD_RESET) begin
        step = 0;
        id_q = 1'b0;
      end else if (step == 0 && p_q.addr == UNLOCK_A1 && dq_q[7:0] == UNLOCK_D1) begin
        step = 1;
      end else if (step == 1 && p_q.addr == UNLOCK_A2 && dq_q[7:0] == UNLOCK_D2) begin
        step = 2;
      end else if (p_q.addr == UNLOCK_A1 && dq_q[7:0] == CMD_PROG && (step == 2 || boost_level)) begin
        step = 3;
      end else if (step == 2 && dq_q[7:0] == 8'h90) begin
        id_q = 1'b1;
        step = 0;
      end else if (step == 2 && dq_q[7:0] == ERASE_CODE) begin
        step = 4;
      end else if (step == 4 && p_q.addr == UNLOCK_A1 && dq_q[7:0] == UNLOCK_D1) begin
        step = 5;
      end else if (step == 5 && p_q.addr == UNLOCK_A2 && dq_q[7:0] == UNLOCK_D2) begin
        step = 6;
      end else if (step == 6 && dq_q[7:0] == SECT_CODE) begin
        // Whole sector goes blank; boot sectors still obey protection
        if (!locked(p_q.addr)) begin
          foreach (mem[k]) if (k[20:16] == p_q.addr[20:16]) ks.push_back(k);
          while (ks.size() > 0) mem.delete(ks.pop_front());
          wiped[p_q.addr[20:16]] = 1'b1;
          last_d = 16'hFFFF;
          busy = BUSY_CYC;
        end
        step = 0;
      end else begin
        step = 0;
      end
    end
    p_q = pins;
    dq_q = dq;
  end

  // Read drive; status and id use the low byte only
  always @* begin
    word = peek(pins.addr);
    lanes = 16'hFFFF;
    dq_out = word;
    if (busy != 0) begin
      dq_out = {8'h00, ~last_d[7], 7'h00};
      lanes = 16'h00FF;
    end else if (id_q) begin
      dq_out = {8'h00, MAKER_CODE};
      lanes = 16'h00FF;
    end else if (!pins.width_select_n) begin
      dq_out = {8'h00, dq[15] ? word[15:8] : word[7:0]};
      lanes = 16'h00FF;
    end
    dq_oe_n = (!pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n
               && pins.hw_reset_n) ? ~lanes : 16'hFFFF;
  end
endmodule // fbod_flash_model

/* File: tb/tb_flash_bus_operation_decode.sv */
// Self-checking bench for the host flash bus controller.
// Assumes the package and the flash model are compiled before this file.
`timescale 1ns/1ps
module tb_flash_bus_operation_decode;
  import fbod_pkg::*;
  typedef struct {logic [15:0] e; logic [15:0] m;} fbod_exp_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  fbod_req_t   req = '0;
  logic        req_valid = 1'b0;
  logic        byte_mode = 1'b0;
  logic        fast_mode = 1'b0;
  logic        protect_en = 1'b0;
  logic        boost_en = 1'b0;
  logic        req_ready, rd_valid, pob_pin, boost_lvl;
  logic [15:0] rd_data, dq_o, dq_oe_n, fl_dq, fl_oe_n, dq;
  logic [15:0] float_pat = 16'h6996;
  fbod_pins_t  pins;
  fbod_exp_t   exp_q[$];
  fbod_exp_t   cur;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_wr = 0;
  logic [20:0] id_a [3] = '{UNLOCK_A1, UNLOCK_A2, UNLOCK_A1};
  logic [15:0] id_d [3] = '{16'h00AA, 16'h0055, 16'h0090};
  logic [7:0]  er_d [6] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h30};

  always #2 clk = ~clk;
  // Released lanes wander every cycle so a stale value never passes
  always @(posedge clk) float_pat <= ~float_pat;
  assign dq = (~dq_oe_n & dq_o) | (dq_oe_n & ~fl_oe_n & fl_dq) | (dq_oe_n & fl_oe_n & float_pat);
  always @(negedge pins.write_strobe_n) n_wr++;

  fbod_host fbod_host_inst (.CLK(clk), .SRST(srst), .REQ(req), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .BYTE_MODE(byte_mode), .FAST_MODE(fast_mode),
    .PROTECT_EN(protect_en), .BOOST_EN(boost_en), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .PINS(pins), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .DQ_I(dq),
    .PROTECT_OR_BOOST_PIN(pob_pin), .BOOST_VOLTAGE_LEVEL(boost_lvl));
  fbod_flash_model #(.BUSY_CYC(40), .MAKER_CODE(8'h3C)) fbod_flash_model_inst (.clk(clk),
    .pins(pins), .dq(dq), .protect_pin(pob_pin), .boost_level(boost_lvl),
    .dq_out(fl_dq), .dq_oe_n(fl_oe_n));

  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for the controller to go idle
  task automatic wait_ready();
    int i;
    i = 0;
    while (req_ready !== 1'b1) begin
      if (i == 400) begin
        n_mismatch++;
        finish_test();
      end
      @(posedge clk);
      #1 i++;
    end
  endtask

  task automatic do_req(fbod_op_t o, logic [20:0] a, logic [15:0] d, logic l);
    wait_ready();
    req = '{op: o, addr: a, data: d, byte_lsb: l};
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask

  task automatic rd(logic [20:0] a, logic l, logic [15:0] e, logic [15:0] m);
    exp_q.push_back('{e & m, m});
    do_req(OP_READ, a, 16'h0000, l);
  endtask

  task automatic prog(logic [20:0] a, logic [15:0] d, logic [15:0] n);
    int n0;
    n0 = n_wr;
    do_req(OP_PROG, a, d, 1'b0);
    wait_ready();
    chk("write cycles", n, 16'(n_wr - n0));
  endtask

  // Result watcher and pin relations
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("spare read", 16'h0000, 16'hFFFF);
      else begin
        cur = exp_q.pop_front();
        chk("read data", cur.e, rd_data & cur.m);
      end
    end
    if (!srst) begin
      if (pins.write_strobe_n === 1'b0) chk("write pins", 16'h0001, {15'h0, pins.output_gate_n & ~pins.chip_select_n});
      if (pins.output_gate_n === 1'b0) chk("read pins", 16'hFFFF, {pins.write_strobe_n, dq_oe_n[14:0]});
      if (pins.chip_select_n === 1'b0) chk("width pin", {15'h0, ~byte_mode}, {15'h0, pins.width_select_n});
      if (byte_mode && pins.chip_select_n === 1'b0) chk("byte lane", 16'h0000, {15'h0, dq_oe_n[15]});
      chk("protect pins", {14'h0, ~protect_en | boost_en, boost_en}, {14'h0, pob_pin, boost_lvl});
    end
  end

  initial begin
    logic [20:0] a, b;
    logic [15:0] d, e;
    void'($urandom(602));
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    a = {5'(1 + $urandom % 30), 16'($urandom)};
    b = {5'h1F, 16'($urandom)};
    d = 16'($urandom);
    e = 16'($urandom);
    rd(a, 1'b0, a[15:0] ^ 16'h5A5A, 16'hFFFF);
    prog(a, d, 16'h0004);
    rd(a, 1'b0, {8'h00, ~d[7], 7'h00}, 16'h00FF);
    rd(a, 1'b0, d, 16'hFFFF);
    protect_en = 1'b1;
    prog(b, e, 16'h0004);
    rd(b, 1'b0, b[15:0] ^ 16'h5A5A, 16'hFFFF);
    boost_en = 1'b1;
    fast_mode = 1'b1;
    prog(b, e, 16'h0002);
    rd(b, 1'b0, {8'h00, ~e[7], 7'h00}, 16'h00FF);
    rd(b, 1'b0, e, 16'hFFFF);
    boost_en = 1'b0;
    fast_mode = 1'b0;
    for (int i = 0; i < 3; i++) do_req(OP_WRITE, id_a[i], id_d[i], 1'b0);
    rd(21'h000000, 1'b0, 16'h003C, 16'h00FF);
    do_req(OP_RESET, 21'h000000, 16'h0000, 1'b0);
    rd(a, 1'b0, d, 16'hFFFF);
    // Width changes only between bus cycles, never inside a read
    wait_ready();
    byte_mode = 1'b1;
    rd(a, 1'b1, {8'h00, d[15:8]}, 16'hFFFF);
    rd(a, 1'b0, {8'h00, d[7:0]}, 16'hFFFF);
    wait_ready();
    byte_mode = 1'b0;
    // Sector erase of a: six raw cycles, then status, then blank data
    for (int i = 0; i < 6; i++)
      do_req(OP_WRITE, (i == 5) ? a : id_a[i % 3], {8'h00, er_d[i]}, 1'b0);
    rd(a, 1'b0, 16'h0000, 16'h00FF);
    rd(a, 1'b0, 16'hFFFF, 16'hFFFF);
    wait_ready();
    if (exp_q.size() != 0) n_mismatch++;
    finish_test();
  end
endmodule // tb_flash_bus_operation_decode
